// ===== hw/sync_serial_port_pkg.sv
// constants, register map and encodings of the synchronous serial port
package sync_serial_port_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets on the axi4-lite bus)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W     = 5;
  localparam logic [4:0]  OFS_CTRL   = 5'h00;
  localparam logic [4:0]  OFS_WLEN   = 5'h04;
  localparam logic [4:0]  OFS_CLKDIV = 5'h08;
  localparam logic [4:0]  OFS_FRAME  = 5'h0C;
  localparam logic [4:0]  OFS_STATUS = 5'h10;

  // ctrl fields
  localparam int unsigned CTRL_EN     = 0;
  localparam int unsigned CTRL_MODE   = 1;
  localparam int unsigned CTRL_DIR    = 3;
  localparam int unsigned CTRL_LSB    = 5;
  localparam int unsigned CTRL_INTCLK = 6;
  localparam int unsigned CTRL_FALL   = 7;
  localparam int unsigned CTRL_COMP   = 8;
  localparam int unsigned CTRL_W      = 12;
  // frame fields
  localparam int unsigned FRAME_SLOTS = 16;
  // status fields
  localparam int unsigned ST_RUN = 0;
  localparam int unsigned ST_UF  = 1;
  localparam int unsigned ST_OF  = 3;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_STD = 2'b00,
    MODE_TDM = 2'b01,
    MODE_I2S = 2'b10,
    MODE_LJ  = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    COMP_NONE = 2'b00,
    COMP_MU   = 2'b01,
    COMP_A    = 2'b10
  } comp_t;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // limits, reset values, timing
  // ----------------------------------------------------------------
  localparam logic [5:0]  WLEN_MIN_STD  = 6'h03;
  localparam logic [5:0]  WLEN_MIN_PAIR = 6'h08;
  localparam logic [5:0]  WLEN_MAX      = 6'h20;
  localparam logic [5:0]  WLEN_RST      = 6'h20;
  localparam logic [15:0] CLKDIV_RST    = 16'h0003;
  localparam logic [15:0] FRAME_LEN_RST = 16'h0040;
  localparam logic [6:0]  SLOTS_RST     = 7'h01;
  localparam int unsigned SLOTS_MAX     = 128;

  localparam int unsigned CLK_KHZ        = 250000;
  localparam int unsigned MAX_RATE_KBPS  = 41670;
  localparam int unsigned MIN_BIT_CYCLES = (CLK_KHZ + MAX_RATE_KBPS - 1) / MAX_RATE_KBPS;
  localparam logic [15:0] MIN_HALF       = 16'((MIN_BIT_CYCLES + 1) / 2);

  // companding constants
  localparam logic [15:0] MU_BIAS   = 16'h0084;
  localparam logic [15:0] MU_CLIP   = 16'h7F7B;
  localparam logic [15:0] A_CLIP    = 16'h0FFF;
  localparam logic [7:0]  A_XOR     = 8'h55;
  localparam logic [15:0] A_SEG_OFS = 16'h0108;
  localparam logic [3:0]  A_HALF    = 4'h8;

endpackage

// ===== hw/sync_serial_port.sv
// synchronous serial port: axi4-lite registers, dma streams, serial link engine
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - two data lines, each independently tx or rx
// - each data line has its own stream
// - bit rate limited to 41.67 Mbit/s; only the internal bclk_o is held to it, an external link_clk is not
// - paired ports share clock and frame sync
// - four modes: standard, tdm, i2s, left-justified
// - left-justified: sample on each frame-sync level
// - i2s/lj: four channels over two lines
// - tdm: up to 128 slots per frame
// - selectable lsb-first or msb-first shifting
// - standard/tdm word length 3 to 32
// - i2s/lj word length 8 to 32
// - per-line mu-law or a-law companding
// - clock and frame sync internal or external
module sync_serial_port (
  // system
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite slave
  input  wire logic [4:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [4:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // dma streams, one pair per data line
  input  wire logic [1:0][31:0]  tx_data,
  input  wire logic [1:0]        tx_valid,
  output logic [1:0]             tx_ready,
  output logic [1:0][31:0]       rx_data,
  output logic [1:0]             rx_valid,
  input  wire logic [1:0]        rx_ready,
  // link pins
  input  wire logic              link_clk,
  output logic                   bclk_o,
  output logic                   bclk_oe,
  input  wire logic              fs_i,
  output logic                   fs_o,
  output logic                   fs_oe,
  input  wire logic [1:0]        data_i,
  output logic [1:0]             data_o,
  output logic [1:0]             data_oe
);

  // ----------------------------------------------------------------
  // companding helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] mu_enc(input logic [15:0] x);
    logic [15:0] mag;
    logic [2:0]  e;
    mag = x[15] ? (~x + 16'h0001) : x;
    if (mag > sync_serial_port_pkg::MU_CLIP) mag = sync_serial_port_pkg::MU_CLIP;
    mag = mag + sync_serial_port_pkg::MU_BIAS;
    e = 3'h0;
    for (int k = 0; k < 8; k++) if (mag[k + 7]) e = 3'(k);
    return ~{x[15], e, mag[4'(e) + 4'h3 +: 4]};
  endfunction

  function automatic logic [7:0] a_enc(input logic [15:0] x);
    logic [15:0] mag;
    logic [2:0]  e;
    mag = x[15] ? (~x + 16'h0001) : x;
    mag = mag >> 3;
    if (mag > sync_serial_port_pkg::A_CLIP) mag = sync_serial_port_pkg::A_CLIP;
    e = 3'h0;
    for (int k = 1; k < 8; k++) if (mag[k + 4]) e = 3'(k);
    return {~x[15], e, mag[((e == 3'h0) ? 4'h1 : 4'(e)) +: 4]} ^ sync_serial_port_pkg::A_XOR;
  endfunction

  function automatic logic [15:0] mu_dec(input logic [7:0] b);
    logic [7:0]  v;
    logic [15:0] t;
    v = ~b;
    t = (({12'h000, v[3:0]} << 3) + sync_serial_port_pkg::MU_BIAS) << v[6:4];
    t = t - sync_serial_port_pkg::MU_BIAS;
    return v[7] ? (~t + 16'h0001) : t;
  endfunction

  function automatic logic [15:0] a_dec(input logic [7:0] b);
    logic [7:0]  v;
    logic [15:0] t;
    v = b ^ sync_serial_port_pkg::A_XOR;
    t = {8'h00, v[3:0], sync_serial_port_pkg::A_HALF};
    if (v[6:4] != 3'h0) t = (t + sync_serial_port_pkg::A_SEG_OFS - 16'h0008) << (v[6:4] - 3'h1);
    return v[7] ? t : (~t + 16'h0001);
  endfunction

  // ----------------------------------------------------------------
  // registers and axi4-lite slave
  // ----------------------------------------------------------------
  logic [11:0] ctrl;
  logic [5:0]  wlen;
  logic [15:0] clkdiv;
  logic [15:0] frame_len;
  logic [6:0]  slots_m1;
  logic [1:0]  uf_flag;
  logic [1:0]  of_flag;
  logic [1:0]  uf_evt;
  logic [1:0]  of_evt;
  logic        run_a;
  logic [4:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic        w_held;
  logic        do_write;
  logic [1:0]  mode_a;
  logic [5:0]  wlen_min;
  logic [5:0]  wlen_eff;

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign mode_a   = ctrl[sync_serial_port_pkg::CTRL_MODE +: 2];

  // word length clamped to the range the chosen mode allows
  always_comb begin
    wlen_min = (mode_a[1]) ? sync_serial_port_pkg::WLEN_MIN_PAIR
                           : sync_serial_port_pkg::WLEN_MIN_STD;
    wlen_eff = wlen;
    if (wlen < wlen_min) wlen_eff = wlen_min;
    if (wlen > sync_serial_port_pkg::WLEN_MAX) wlen_eff = sync_serial_port_pkg::WLEN_MAX;
  end

  // address and data are taken in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 5'h00;
      w_data        <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= sync_serial_port_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      s_axi_wready  <= !w_held && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr > sync_serial_port_pkg::OFS_STATUS || aw_addr[1:0] != 2'b00)
                        ? sync_serial_port_pkg::RESP_SLVERR : sync_serial_port_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes; strobes are ignored, each write replaces the word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl      <= 12'h000;
      wlen      <= sync_serial_port_pkg::WLEN_RST;
      clkdiv    <= sync_serial_port_pkg::CLKDIV_RST;
      frame_len <= sync_serial_port_pkg::FRAME_LEN_RST;
      slots_m1  <= sync_serial_port_pkg::SLOTS_RST;
    end else if (do_write) begin
      unique case (aw_addr)
        sync_serial_port_pkg::OFS_CTRL:   ctrl   <= w_data[11:0];
        sync_serial_port_pkg::OFS_WLEN:   wlen   <= w_data[5:0];
        sync_serial_port_pkg::OFS_CLKDIV: clkdiv <= w_data[15:0];
        sync_serial_port_pkg::OFS_FRAME: begin
          frame_len <= w_data[15:0];
          slots_m1  <= w_data[sync_serial_port_pkg::FRAME_SLOTS +: 7];
        end
        default: ;
      endcase
    end
  end

  // sticky error flags: write one to clear, a new event wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uf_flag <= 2'b00;
      of_flag <= 2'b00;
    end else begin
      uf_flag <= uf_evt | (uf_flag & ~((do_write && aw_addr == sync_serial_port_pkg::OFS_STATUS)
                 ? w_data[sync_serial_port_pkg::ST_UF +: 2] : 2'b00));
      of_flag <= of_evt | (of_flag & ~((do_write && aw_addr == sync_serial_port_pkg::OFS_STATUS)
                 ? w_data[sync_serial_port_pkg::ST_OF +: 2] : 2'b00));
    end
  end

  // read channel, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= sync_serial_port_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= sync_serial_port_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
          sync_serial_port_pkg::OFS_CTRL:   s_axi_rdata <= {20'h00000, ctrl};
          sync_serial_port_pkg::OFS_WLEN:   s_axi_rdata <= {26'h0000000, wlen_eff};
          sync_serial_port_pkg::OFS_CLKDIV: s_axi_rdata <= {16'h0000, half_per};
          sync_serial_port_pkg::OFS_FRAME:  s_axi_rdata <= {9'h000, slots_m1, frame_len};
          sync_serial_port_pkg::OFS_STATUS: s_axi_rdata <= {27'h0000000, of_flag, uf_flag, run_a};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= sync_serial_port_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // internal bit clock: never faster than the serial rate limit
  // ----------------------------------------------------------------
  logic [15:0] div_cnt;
  logic [15:0] half_per;

  assign half_per = (clkdiv < sync_serial_port_pkg::MIN_HALF)
                    ? sync_serial_port_pkg::MIN_HALF : clkdiv;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= 16'h0000;
      bclk_o  <= 1'b0;
      bclk_oe <= 1'b0;
    end else begin
      bclk_oe <= ctrl[sync_serial_port_pkg::CTRL_INTCLK];
      if (div_cnt >= half_per - 16'h0001) begin
        div_cnt <= 16'h0000;
        bclk_o  <= ~bclk_o;
      end else begin
        div_cnt <= div_cnt + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // link domain: reset, enable and configuration capture
  // ----------------------------------------------------------------
  logic [1:0]  rst_sync;
  logic [1:0]  en_sync;
  logic [1:0]  run_sync;
  logic        run_l;
  logic [1:0]  l_mode;
  logic [1:0]  l_dir;
  logic        l_lsb;
  logic        l_int;
  logic        l_fall;
  logic [5:0]  l_wlen;
  logic [15:0] l_flen;
  logic [6:0]  l_slots;

  always_ff @(posedge link_clk) begin
    rst_sync <= {rst_sync[0], aresetn};
    en_sync  <= {en_sync[0], ctrl[sync_serial_port_pkg::CTRL_EN]};
  end

  assign run_l = rst_sync[1] && en_sync[1];

  // configuration is copied only while stopped, so it is frozen while running
  always_ff @(posedge link_clk) begin
    if (!run_l) begin
      l_mode  <= mode_a;
      l_dir   <= ctrl[sync_serial_port_pkg::CTRL_DIR +: 2];
      l_lsb   <= ctrl[sync_serial_port_pkg::CTRL_LSB];
      l_int   <= ctrl[sync_serial_port_pkg::CTRL_INTCLK];
      l_fall  <= ctrl[sync_serial_port_pkg::CTRL_FALL];
      l_wlen  <= wlen_eff;
      l_flen  <= frame_len;
      l_slots <= slots_m1;
    end
  end

  always_ff @(posedge aclk) begin
    run_sync <= {run_sync[0], run_l};
    run_a    <= run_sync[1];
  end

  // ----------------------------------------------------------------
  // frame sync generation and word start detection
  // ----------------------------------------------------------------
  logic [15:0] fcnt;
  logic        fs_s;
  logic        fs_q;
  logic        fs_qq;
  logic        word_start;
  logic        chain;
  logic        active;
  logic [4:0]  bitc;
  logic [6:0]  slot;
  logic        last_bit;

  // internal sync; an external sync is shared by a paired port
  always_ff @(posedge link_clk) begin
    if (!run_l) begin
      fcnt  <= 16'h0000;
      fs_o  <= 1'b0;
      fs_oe <= 1'b0;
      fs_s  <= 1'b0;
      fs_q  <= 1'b0;
      fs_qq <= 1'b0;
    end else begin
      fs_oe <= l_int;
      fcnt  <= (fcnt >= l_flen - 16'h0001) ? 16'h0000 : fcnt + 16'h0001;
      unique case (l_mode)
        sync_serial_port_pkg::MODE_I2S: fs_o <= (fcnt >= (l_flen >> 1));   // left while low
        sync_serial_port_pkg::MODE_LJ:  fs_o <= (fcnt < (l_flen >> 1));
        default:                        fs_o <= (fcnt == l_flen - 16'h0001);
      endcase
      fs_s  <= l_int ? fs_o : fs_i;
      fs_q  <= fs_s;
      fs_qq <= fs_q;
    end
  end

  // i2s starts one bit after either sync edge, lj on the edge itself
  always_comb begin
    unique case (l_mode)
      sync_serial_port_pkg::MODE_I2S: word_start = fs_q ^ fs_qq;
      sync_serial_port_pkg::MODE_LJ:  word_start = fs_s ^ fs_q;
      default:                        word_start = fs_q && !fs_qq;
    endcase
  end

  assign last_bit = ({1'b0, bitc} == l_wlen - 6'h01);
  assign chain    = active && last_bit && l_mode == sync_serial_port_pkg::MODE_TDM
                    && slot < l_slots;

  // shared bit and slot counters for both lines
  always_ff @(posedge link_clk) begin
    if (!run_l) begin
      active <= 1'b0;
      bitc   <= 5'h00;
      slot   <= 7'h00;
    end else if (word_start || chain) begin
      active <= 1'b1;
      bitc   <= 5'h00;
      slot   <= chain ? slot + 7'h01 : 7'h00;
    end else if (active) begin
      active <= !last_bit;
      bitc   <= bitc + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // per-line datapath, stream handshakes and domain crossings
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_line
    logic [31:0] tx_hold;
    logic        tx_req;
    logic [1:0]  tx_ack_s;
    logic [1:0]  tx_req_s;
    logic        tx_ack;
    logic [31:0] tx_word;
    logic [4:0]  idx;
    logic        rx_bit;
    logic        rx_neg;
    logic        tx_pos;
    logic        tx_neg;
    logic [31:0] rx_sh;
    logic [31:0] rx_hold;
    logic        rx_tgl;
    logic [2:0]  rx_s;
    logic        uf_tgl;
    logic [2:0]  uf_s;
    logic [1:0]  comp;

    assign comp   = ctrl[sync_serial_port_pkg::CTRL_COMP + 2 * i +: 2];
    assign idx    = l_lsb ? bitc : 5'(l_wlen - 6'h01 - {1'b0, bitc});
    assign rx_bit = l_fall ? rx_neg : data_i[i];

    // dma side of transmit: compress on load, hand over by toggle
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        tx_hold     <= 32'h0000_0000;
        tx_req      <= 1'b0;
        tx_ack_s    <= 2'b00;
        tx_ready[i] <= 1'b0;
      end else begin
        tx_ack_s <= {tx_ack_s[0], tx_ack};
        if (tx_valid[i] && tx_ready[i]) begin
          unique case (comp)
            sync_serial_port_pkg::COMP_MU: tx_hold <= {24'h000000, mu_enc(tx_data[i][15:0])};
            sync_serial_port_pkg::COMP_A:  tx_hold <= {24'h000000, a_enc(tx_data[i][15:0])};
            default:                       tx_hold <= tx_data[i];
          endcase
          tx_req      <= ~tx_req;
          tx_ready[i] <= 1'b0;
        end else begin
          tx_ready[i] <= (tx_req == tx_ack_s[1]) && ctrl[sync_serial_port_pkg::CTRL_DIR + i];
        end
      end
    end

    // link side: take a word at each start, zeros and a flag if none
    always_ff @(posedge link_clk) begin
      tx_req_s <= {tx_req_s[0], tx_req};
      if (!run_l) begin
        // only reset aligns the toggles; a word loaded while stopped stays pending
        if (!rst_sync[1]) tx_ack <= tx_req_s[1];
        tx_word <= 32'h0000_0000;
        uf_tgl  <= 1'b0;
      end else if ((word_start || chain) && l_dir[i]) begin
        if (tx_req_s[1] != tx_ack) begin
          tx_word <= tx_hold;
          tx_ack  <= ~tx_ack;
        end else begin
          tx_word <= 32'h0000_0000;
          uf_tgl  <= ~uf_tgl;
        end
      end
    end

    // pin stages: one register per edge, data_o is driven on the rising edge whichever edge samples
    always_ff @(negedge link_clk) begin
      rx_neg <= data_i[i];
      tx_neg <= tx_word[idx] && active;
    end

    always_ff @(posedge link_clk) begin
      tx_pos     <= tx_word[idx] && active;
      data_o[i]  <= l_fall ? tx_pos : tx_neg;
      data_oe[i] <= run_l && l_dir[i];
    end

    // receive shift register, word handed over by toggle
    always_ff @(posedge link_clk) begin
      if (!run_l) begin
        rx_sh   <= 32'h0000_0000;
        rx_hold <= 32'h0000_0000;
        rx_tgl  <= 1'b0;
      end else if (active && !l_dir[i]) begin
        rx_sh[idx] <= rx_bit;
        if (last_bit) begin
          rx_hold      <= rx_sh;
          rx_hold[idx] <= rx_bit;
          rx_tgl       <= ~rx_tgl;
        end
      end
    end

    // dma side of receive: expand, present, flag overrun
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        rx_s        <= 3'b000;
        uf_s        <= 3'b000;
        rx_valid[i] <= 1'b0;
        rx_data[i]  <= 32'h0000_0000;
      end else begin
        rx_s <= {rx_s[1:0], rx_tgl};
        uf_s <= {uf_s[1:0], uf_tgl};
        if (rx_s[2] != rx_s[1]) begin
          rx_valid[i] <= 1'b1;
          unique case (comp)
            sync_serial_port_pkg::COMP_MU: rx_data[i] <= 32'(signed'(mu_dec(rx_hold[7:0])));
            sync_serial_port_pkg::COMP_A:  rx_data[i] <= 32'(signed'(a_dec(rx_hold[7:0])));
            default:                       rx_data[i] <= rx_hold;
          endcase
        end else if (rx_ready[i]) begin
          rx_valid[i] <= 1'b0;
        end
      end
    end

    assign of_evt[i] = (rx_s[2] != rx_s[1]) && rx_valid[i] && !rx_ready[i];
    assign uf_evt[i] = (uf_s[2] != uf_s[1]);
  end

endmodule

`default_nettype wire

// ===== dv/serial_codec_model.sv
// far-side codec: free bit clock, frame sync and one word each way
`timescale 1ns/10ps
`default_nettype none
module serial_codec_model #(
  parameter logic [7:0] RX_WORD = 8'h35
) (
  // link pins
  output logic            link_clk,
  output logic            fs,
  output logic [1:0]      sdo,
  input  wire logic       sdi,
  // bench side
  input  wire logic [7:0] want,
  output logic            seen
);
  // --------
  // clock and framing, 16 bits a frame
  // --------
  logic [3:0] cnt = '0;
  logic [7:0] sh = '0;
  logic [7:0] last = '0;
  // 48 ns bit clock keeps well inside the rate ceiling
  initial begin
    link_clk = 1'b0;
    fs = 1'b0;
    sdo = 2'b00;
    seen = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  // sample on rising edges, msb first, eight bits once the port's sync latency has passed
  always @(posedge link_clk) begin
    cnt <= cnt + 4'h1;
    if (cnt >= 4'h3 && cnt < 4'hB) sh <= {sh[6:0], sdi};
    if (cnt == 4'hB && sh == want) seen <= 1'b1;
    if (want != last) seen <= 1'b0;
    last <= want;
  end
  // drive on falling edges; idle bits toggle so stale levels never pass
  always @(negedge link_clk) begin
    fs <= (cnt == 4'hF);
    sdo[0] <= ~sdo[0];
    sdo[1] <= (cnt >= 4'h2 && cnt < 4'hA) ? RX_WORD[3'(4'h9 - cnt)] : ~sdo[1];
  end
endmodule
`default_nettype wire

// ===== dv/sync_serial_port_assertions.sv
// concurrent checks on the port's bus, stream and bit clock pins
`timescale 1ns/10ps
`default_nettype none
module sync_serial_port_assertions (
  // system
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic [4:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // streams and clock
  input wire logic [1:0]  tx_valid,
  input wire logic [1:0]  tx_ready,
  input wire logic [1:0]  rx_valid,
  input wire logic [1:0]  rx_ready,
  input wire logic        bclk_o
);
  // --------
  // checks, system clock domain only
  // --------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // half period of three cycles at least keeps the rate ceiling
  sequence bclk_steady;
    $stable(bclk_o)[*2];
  endsequence
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data moved");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 5'h10
    |=> s_axi_rresp == sync_serial_port_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answered");
  a_good_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 5'h04
    |=> s_axi_rresp == sync_serial_port_pkg::RESP_OKAY)
    else $error("mapped read refused");
  a_tx_taken: assert property (tx_valid[0] && tx_ready[0] |=> !tx_ready[0])
    else $error("tx slot not closed");
  a_rx_held: assert property (rx_valid[1] && !rx_ready[1] |=> rx_valid[1])
    else $error("rx word dropped");
  a_bclk_rate: assert property ($changed(bclk_o) |=> bclk_steady)
    else $error("bit clock too fast");
endmodule
bind sync_serial_port sync_serial_port_assertions chk (.*);
`default_nettype wire

// ===== dv/sync_serial_port_tb.sv
// self-checking bench for the synchronous serial port
`timescale 1ns/10ps
`default_nettype none
module sync_serial_port_tb;
  // --------
  // pins, far side and clock
  // --------
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, bclk_o, bclk_oe, fs_o, fs_oe;
  logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, tx_valid = 0, tx_ready, rx_valid, rx_ready = 0;
  logic [1:0] data_o, data_oe;
  logic [1:0][31:0] tx_data = 0, rx_data;
  logic [7:0] want = 0;
  wire link_clk, fs_i, seen;
  wire [1:0] data_i;
  int err_total = 0, n_checks = 0, cyc = 0;
  sync_serial_port uut (.*);
  serial_codec_model far (.link_clk, .fs(fs_i), .sdo(data_i), .sdi(data_o[0]), .want, .seen);
  always #2 aclk = ~aclk;
  // a hang ends through the same report
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // --------
  // bus cycles: hold each channel until its own ready
  // --------
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic wrc(input logic [4:0] a, input logic [31:0] v, input logic [31:0] e);
    wr(a, v);
    rd(a);
    chk("register", e, d);
  endtask
  // --------
  // main sequence
  // --------
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    rd(sync_serial_port_pkg::OFS_WLEN);
    chk("wlen reset", 32'(sync_serial_port_pkg::WLEN_RST), d);
    wrc(sync_serial_port_pkg::OFS_CLKDIV, 32'h1, 32'(sync_serial_port_pkg::MIN_HALF));
    // every mode; a short length rises to that mode's floor
    for (int m = 0; m < 4; m++) begin
      wr(sync_serial_port_pkg::OFS_CTRL, 32'(m << 1));
      wrc(sync_serial_port_pkg::OFS_WLEN, 32'h2, m < 2 ? 32'h3 : 32'h8);
    end
    wrc(sync_serial_port_pkg::OFS_WLEN, 32'h21, 32'h20);
    wr(5'h14, 32'h1);
    chk("bad write", 32'(sync_serial_port_pkg::RESP_SLVERR), 32'(r));
    rd(5'h02);
    chk("bad read", 32'(sync_serial_port_pkg::RESP_SLVERR), 32'(r));
    chk("bad rdata", 32'h0, d);
    wr(sync_serial_port_pkg::OFS_CTRL, 32'h41);
    repeat (40) @(posedge aclk);
    chk("bclk drive", 32'h1, 32'(bclk_oe));
    wr(sync_serial_port_pkg::OFS_CTRL, 32'h40);
    // line 0 sends, line 1 receives, external clock, both bit orders
    for (int o = 0; o < 2; o++) begin
      wr(sync_serial_port_pkg::OFS_WLEN, 32'h8);
      wr(sync_serial_port_pkg::OFS_CTRL, 32'h8 | 32'(o << 5));
      chk("rx line ready", 32'h0, 32'(tx_ready[1]));
      @(posedge aclk);
      tx_data[0] <= 32'hA6;
      tx_valid[0] <= 1;
      do @(posedge aclk); while (!tx_ready[0]);
      tx_valid[0] <= 0;
      want <= o ? 8'h65 : 8'hA6;
      wr(sync_serial_port_pkg::OFS_CTRL, 32'h9 | 32'(o << 5));
      repeat (2000) @(posedge aclk);
      rx_ready[1] <= 1;
      @(posedge aclk);
      rx_ready[1] <= 0;
      do @(posedge aclk); while (!rx_valid[1]);
      chk("rx word", o ? 32'hAC : 32'h35, rx_data[1]);
      chk("tx word", 32'h1, 32'(seen));
      wr(sync_serial_port_pkg::OFS_CTRL, 32'h8);
    end
    finish_test();
  end
endmodule
`default_nettype wire
